//--- core/gyro_spi_pkg.sv
`default_nettype none

package gyro_spi_pkg;

    // ------------------------------------------------------------
    // Word framing
    // ------------------------------------------------------------
    localparam logic [4:0] WORD_LAST_PLAIN = 5'h0F;
    localparam logic [4:0] WORD_LAST_PARITY = 5'h10;
    localparam int ADDR_MSB = 9;
    localparam int ADDR_LSB = 3;
    localparam int RW_BIT = 2;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [6:0] ADDR_RATE = 7'h00;
    localparam logic [6:0] ADDR_IDENT = 7'h07;
    localparam logic [6:0] ADDR_STATUS = 7'h08;
    localparam logic [6:0] ADDR_TEMP = 7'h0A;
    // Bit positions within the 16-bit register / data word
    localparam int IDENT_PAR_EN_BIT = 12;
    localparam int IDENT_PAR_SEL_BIT = 13;
    localparam int STATUS_PAR_OK_BIT = 9;
    // Same bit positions within the 15-bit value field (word bit minus one)
    localparam int VAL_PAR_EN_IDX = IDENT_PAR_EN_BIT - 1;
    localparam int VAL_PAR_SEL_IDX = IDENT_PAR_SEL_BIT - 1;
    // Position of the parity-ok flag inside the 14 monitoring flags (bits 15:2)
    localparam int MON_PAR_OK_IDX = STATUS_PAR_OK_BIT - 2;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic PAR_EN_RST = 1'b0;
    localparam logic PAR_SEL_RST = 1'b0;
    localparam logic PAR_OK_RST = 1'b1;
    // Pin order {chip select, data in, serial clock}; select idles high
    localparam logic [2:0] PIN_SYNC_RST = 3'h4;
    localparam logic [16:0] TX_RST = 17'h00000;

    typedef enum logic {
        ST_ADDR,
        ST_WDATA
    } word_state_t;

    // ------------------------------------------------------------
    // Parity helpers
    // ------------------------------------------------------------
    // D0: one when D15..D1 hold an even number of ones
    function automatic logic odd_bit(input logic [14:0] v);
        odd_bit = ~(^v);
    endfunction : odd_bit

    // Extra bit: sel=0 gives even total, sel=1 odd total
    function automatic logic extra_bit(input logic [15:0] w, input logic sel);
        extra_bit = sel ? ~(^w) : (^w);
    endfunction : extra_bit

    // Full outgoing word: value, D0 parity, then the optional extra bit
    function automatic logic [16:0] tx_word(input logic [14:0] v, input logic sel);
        logic [15:0] w;
        w = {v, odd_bit(v)};
        tx_word = {w, extra_bit(w, sel)};
    endfunction : tx_word

endpackage : gyro_spi_pkg

`default_nettype wire

//--- core/pin_sync.sv
`default_nettype none

module pin_sync
    import gyro_spi_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic [2:0] pins_i,
    output logic [2:0] pins_o
);

    logic [2:0] stage1_reg;
    logic [2:0] stage2_reg;
    logic [2:0] stage3_reg;
    logic [2:0] stable_reg;

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            stage1_reg <= PIN_SYNC_RST;
            stage2_reg <= PIN_SYNC_RST;
            stage3_reg <= PIN_SYNC_RST;
        end else begin
            stage1_reg <= pins_i;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
        end
    end

    // A change counts only once two later stages agree
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            stable_reg <= PIN_SYNC_RST;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (stage2_reg[i] == stage3_reg[i]) begin
                    stable_reg[i] <= stage3_reg[i];
                end
            end
        end
    end

    assign pins_o = stable_reg;

endmodule : pin_sync

`default_nettype wire

//--- core/gyro_spi_slave.sv
// Overview of operation
// - Slave only; master drives serial clock and select, never starts transfers.
// - Words are sixteen bits, one per clock, select low, parity mode off.
// - Data out changes on falling clock, data in sampled on rising, MSB first.
// - First word after select falls is address: address 9:3, direction 2.
// - Direction bit one means write, zero means read.
// - Bit 0 of every word is odd parity over bits 15 to 1.
// - Read answer comes in next word; that next word is a new address.
// - Write stores next word; meanwhile old register value is returned.
// - After write data word, status flags return while next address arrives.
// - First word of a frame answers status flags: valid bit 1, parity.
// - Valid flag derives from monitoring flags in status register 08h.
// - Nonexistent address reads back zero value.
// - Result word: 15-bit value in bits 15 to 1, parity bit 0.
// - Parity mode adds one bit: seventeen clocks per word.
// - Parity failure on read sets error flag; data still returned.
// - Parity failure in write address or data sets flag, cancels write.
// - Parity mode: extra bit sent and checked by selected polarity.
// - Valid flag is one only when status bits 15 to 2 are one.
// - Identification bit 12 enables parity mode; bit 13 selects polarity.
// - Status bit 9 zero after parity error; cleared on status read.
`default_nettype none

module gyro_spi_slave
    import gyro_spi_pkg::*;
#(
    // Factory field of the identification register; value is arbitrary
    parameter logic [14:0] IDENT_FACTORY = 15'h0000
) (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic sck_i,
    input wire logic mosi_i,
    input wire logic rate_select_n_i,
    input wire logic [13:0] rate_value_i,
    input wire logic [13:0] temp_value_i,
    input wire logic [13:0] monitor_flags_i,
    output logic miso_o,
    output logic miso_oe_o,
    output logic parity_mode_enable_o,
    output logic parity_polarity_select_o,
    output logic parity_ok_o,
    output logic sensor_valid_o
);

    // ------------------------------------------------------------
    // Pin synchronisation and edge detection
    // ------------------------------------------------------------
    logic [2:0] pins_s;
    logic sck_s;
    logic mosi_s;
    logic csn_s;
    logic sck_q;
    logic csn_q;
    logic sck_rise;
    logic sck_fall;
    logic cs_fall;
    logic cs_rise;

    pin_sync u_pin_sync (
        .core_clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .pins_i({rate_select_n_i, mosi_i, sck_i}),
        .pins_o(pins_s)
    );

    assign sck_s = pins_s[0];
    assign mosi_s = pins_s[1];
    assign csn_s = pins_s[2];

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sck_q <= 1'b0;
            csn_q <= 1'b1;
        end else begin
            sck_q <= sck_s;
            csn_q <= csn_s;
        end
    end

    // Clock edges count only inside a frame
    assign sck_rise = sck_s & ~sck_q & ~csn_s;
    assign sck_fall = ~sck_s & sck_q & ~csn_s;
    assign cs_fall = ~csn_s & csn_q;
    assign cs_rise = csn_s & ~csn_q;

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic par_en_reg;
    logic par_sel_reg;
    logic parity_ok_reg;
    logic [13:0] status_hi;
    logic s_ok;

    always_comb begin
        status_hi = monitor_flags_i;
        status_hi[MON_PAR_OK_IDX] = parity_ok_reg;
    end

    assign s_ok = &status_hi;

    // ------------------------------------------------------------
    // Receive shifter
    // ------------------------------------------------------------
    logic [15:0] rx_shift_reg;
    logic [4:0] rx_cnt_reg;
    logic [4:0] last_idx;
    logic word_done;
    logic [15:0] rx_word;
    logic perr;

    assign last_idx = par_en_reg ? WORD_LAST_PARITY : WORD_LAST_PLAIN;
    assign word_done = sck_rise && (rx_cnt_reg == last_idx);
    // In parity mode the last sampled bit is the extra bit, not part of the word
    assign rx_word = par_en_reg ? rx_shift_reg : {rx_shift_reg[14:0], mosi_s};
    assign perr = par_en_reg && (mosi_s != extra_bit(rx_word, par_sel_reg));

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rx_shift_reg <= 16'h0000;
            rx_cnt_reg <= 5'h00;
        end else if (cs_fall || cs_rise) begin
            rx_cnt_reg <= 5'h00;
        end else if (sck_rise) begin
            rx_shift_reg <= {rx_shift_reg[14:0], mosi_s};
            rx_cnt_reg <= word_done ? 5'h00 : 5'(rx_cnt_reg + 5'h01);
        end
    end

    // ------------------------------------------------------------
    // Word decoding
    // ------------------------------------------------------------
    word_state_t state_reg;
    logic [6:0] wr_addr_reg;
    logic wr_cancel_reg;
    logic [6:0] rx_addr;
    logic rx_write;
    logic [14:0] rd_val;
    logic [14:0] ident_val;
    logic [16:0] next_tx;
    logic status_clear;

    assign rx_addr = rx_word[ADDR_MSB:ADDR_LSB];
    assign rx_write = rx_word[RW_BIT];

    always_comb begin
        ident_val = IDENT_FACTORY;
        ident_val[VAL_PAR_EN_IDX] = par_en_reg;
        ident_val[VAL_PAR_SEL_IDX] = par_sel_reg;
    end

    // Read value of the addressed register, bits 15:1
    always_comb begin
        case (rx_addr)
            ADDR_RATE: rd_val = {rate_value_i, s_ok};
            ADDR_IDENT: rd_val = ident_val;
            ADDR_STATUS: rd_val = {status_hi, 1'b0};
            ADDR_TEMP: rd_val = {temp_value_i, s_ok};
            default: rd_val = 15'h0000;
        endcase
    end

    // Data answered on the word that follows the one just completed
    always_comb begin
        case (state_reg)
            ST_ADDR: next_tx = tx_word(rd_val, par_sel_reg);
            ST_WDATA: next_tx = tx_word({14'h0000, s_ok}, par_sel_reg);
            default: next_tx = TX_RST;
        endcase
    end

    assign status_clear = word_done && (state_reg == ST_ADDR) && !rx_write
        && (rx_addr == ADDR_STATUS);

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_reg <= ST_ADDR;
            wr_addr_reg <= 7'h00;
            wr_cancel_reg <= 1'b0;
        end else if (cs_fall || cs_rise) begin
            state_reg <= ST_ADDR;
            wr_cancel_reg <= 1'b0;
        end else if (word_done) begin
            case (state_reg)
                ST_ADDR: begin
                    if (rx_write) begin
                        state_reg <= ST_WDATA;
                        wr_addr_reg <= rx_addr;
                        wr_cancel_reg <= perr;
                    end else begin
                        state_reg <= ST_ADDR;
                    end
                end
                ST_WDATA: begin
                    state_reg <= ST_ADDR;
                    wr_cancel_reg <= 1'b0;
                end
                default: begin
                    state_reg <= ST_ADDR;
                end
            endcase
        end
    end

    // Only the identification control bits are writable; the rest ignore writes
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            par_en_reg <= PAR_EN_RST;
            par_sel_reg <= PAR_SEL_RST;
        end else if (word_done && (state_reg == ST_WDATA) && !perr && !wr_cancel_reg
                     && (wr_addr_reg == ADDR_IDENT)) begin
            par_en_reg <= rx_word[IDENT_PAR_EN_BIT];
            par_sel_reg <= rx_word[IDENT_PAR_SEL_BIT];
        end
    end

    // Error wins over a clear in the same cycle
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            parity_ok_reg <= PAR_OK_RST;
        end else if (word_done && perr) begin
            parity_ok_reg <= 1'b0;
        end else if (status_clear) begin
            parity_ok_reg <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Transmit shifter
    // ------------------------------------------------------------
    logic [16:0] tx_shift_reg;
    logic [16:0] tx_pend_reg;
    logic pend_valid_reg;
    logic sampled_reg;
    logic miso_oe_reg;

    // Shift only after a rising edge, so an idle-high clock cannot eat the MSB
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sampled_reg <= 1'b0;
        end else if (cs_fall || cs_rise) begin
            sampled_reg <= 1'b0;
        end else if (sck_rise) begin
            sampled_reg <= 1'b1;
        end else if (sck_fall) begin
            sampled_reg <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tx_pend_reg <= TX_RST;
            pend_valid_reg <= 1'b0;
        end else if (cs_fall || cs_rise) begin
            pend_valid_reg <= 1'b0;
        end else if (word_done) begin
            tx_pend_reg <= next_tx;
            pend_valid_reg <= 1'b1;
        end else if (sck_fall && sampled_reg) begin
            pend_valid_reg <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tx_shift_reg <= TX_RST;
        end else if (cs_fall) begin
            tx_shift_reg <= tx_word({14'h0000, s_ok}, par_sel_reg);
        end else if (sck_fall && sampled_reg) begin
            if (pend_valid_reg) begin
                tx_shift_reg <= tx_pend_reg;
            end else begin
                tx_shift_reg <= {tx_shift_reg[15:0], 1'b0};
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            miso_oe_reg <= 1'b0;
        end else if (cs_fall) begin
            miso_oe_reg <= 1'b1;
        end else if (cs_rise) begin
            miso_oe_reg <= 1'b0;
        end
    end

    assign miso_o = tx_shift_reg[16];
    assign miso_oe_o = miso_oe_reg;
    assign parity_mode_enable_o = par_en_reg;
    assign parity_polarity_select_o = par_sel_reg;
    assign parity_ok_o = parity_ok_reg;
    assign sensor_valid_o = s_ok;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_miso_release: assert property (
        @(posedge core_clk_i) disable iff (!rstn_i)
        cs_rise |=> !miso_oe_o && (state_reg == ST_ADDR) && (rx_cnt_reg == 5'h00))
        else $error("data out not released after select rise");

    a_status_first: assert property (
        @(posedge core_clk_i) disable iff (!rstn_i)
        cs_fall |=> miso_oe_o && (tx_shift_reg[16:2] == {14'h0000, $past(s_ok)}))
        else $error("first word is not the status flags");

    a_parity_gen: assert property (
        @(posedge core_clk_i) disable iff (!rstn_i)
        word_done |=> (^tx_pend_reg[16:1]) == 1'b1)
        else $error("outgoing word lacks odd parity");

    a_unmapped_zero: assert property (
        @(posedge core_clk_i) disable iff (!rstn_i)
        word_done && (state_reg == ST_ADDR) && (rx_addr inside {7'h01, 7'h09, 7'h7F})
        |=> tx_pend_reg[16:1] == 16'h0001)
        else $error("nonexistent address did not read zero");

    a_wdata_status: assert property (
        @(posedge core_clk_i) disable iff (!rstn_i)
        word_done && (state_reg == ST_WDATA)
        |=> (state_reg == ST_ADDR) && (tx_pend_reg[16:3] == 14'h0000))
        else $error("write data word not followed by status flags");

    a_write_cancel: assert property (
        @(posedge core_clk_i) disable iff (!rstn_i)
        word_done && (state_reg == ST_WDATA) && (perr || wr_cancel_reg)
        |=> $stable(par_en_reg) && $stable(par_sel_reg) && !parity_ok_reg)
        else $error("write with parity failure was not cancelled");

    a_read_error: assert property (
        @(posedge core_clk_i) disable iff (!rstn_i)
        word_done && (state_reg == ST_ADDR) && !rx_write && perr
        |=> !parity_ok_reg && (tx_pend_reg[16:2] == $past(rd_val)))
        else $error("read parity failure handled wrongly");

    a_word_length: assert property (
        @(posedge core_clk_i) disable iff (!rstn_i)
        sck_rise && (rx_cnt_reg == 5'h0F) && !par_en_reg |=> rx_cnt_reg == 5'h00)
        else $error("plain word is not sixteen clocks");

    a_status_clear: assert property (
        @(posedge core_clk_i) disable iff (!rstn_i)
        status_clear && !perr |=> parity_ok_reg ##1 parity_ok_reg || word_done)
        else $error("status read did not clear parity flag");

    a_valid_flag: assert property (
        @(posedge core_clk_i) disable iff (!rstn_i)
        sensor_valid_o |-> parity_ok_reg && (&monitor_flags_i[13:8]) && (&monitor_flags_i[6:0]))
        else $error("valid flag high with a monitoring flag low");

endmodule : gyro_spi_slave

`default_nettype wire

//--- verification/spi_master_model.sv
`default_nettype none

module spi_master_model (
    input wire logic core_clk_i,
    input wire logic miso_i,
    output logic sck_o,
    output logic mosi_o,
    output logic select_n_o
);
    timeunit 1ns;
    timeprecision 100ps;

    logic par_odd;
    logic corrupt;
    logic rx_ext;

    initial begin
        sck_o = 1'b0;
        mosi_o = 1'b0;
        select_n_o = 1'b1;
        par_odd = 1'b0;
        corrupt = 1'b0;
        rx_ext = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask : wait_clk

    task automatic frame_begin();
        select_n_o <= 1'b0;
        wait_clk(20);
    endtask : frame_begin

    task automatic frame_end();
        wait_clk(20);
        select_n_o <= 1'b1;
        wait_clk(30);
    endtask : frame_end

    // --------------------------------------------------------
    // One word, MSB first; nb below 16 cuts the word short
    // --------------------------------------------------------
    task automatic xfer(input logic [15:0] tx, input int nb, output logic [15:0] rx);
        logic [16:0] sh;
        logic [16:0] got;
        sh = {tx, (par_odd ? ~(^tx) : ^tx) ^ corrupt};
        got = 17'h00000;
        for (int i = 16; i > 16 - nb; i--) begin
            mosi_o <= sh[i];
            wait_clk(12);
            sck_o <= 1'b1;
            got[i] = miso_i;
            wait_clk(13);
            sck_o <= 1'b0;
        end
        rx = got[16:1];
        rx_ext = got[0];
        wait_clk(12);
    endtask : xfer
endmodule : spi_master_model

`default_nettype wire

//--- verification/gyro_spi_slave_parity_tb.sv
`default_nettype none

module gyro_spi_slave_parity_tb
    import gyro_spi_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic core_clk;
    logic rstn;
    logic [13:0] rate;
    logic [13:0] temp;
    logic [13:0] flags;
    logic sck;
    logic mosi;
    logic sel_n;
    logic miso;
    logic miso_oe;
    logic miso_last;
    logic miso_w;
    logic par_en;
    logic par_sel;
    logic par_ok;
    logic s_valid;
    logic [15:0] rx;
    int nbits;
    int n_fail;
    int cmp_count;

    always #2.5 core_clk = ~core_clk;

    // Released line shows the inverse of its last level
    always @(posedge core_clk) if (miso_oe === 1'b1) miso_last <= miso;
    assign miso_w = (miso_oe === 1'b1) ? miso : ~miso_last;

    gyro_spi_slave #(.IDENT_FACTORY(15'h0000)) dut (
        .core_clk_i(core_clk), .rstn_i(rstn), .sck_i(sck), .mosi_i(mosi),
        .rate_select_n_i(sel_n), .rate_value_i(rate), .temp_value_i(temp),
        .monitor_flags_i(flags), .miso_o(miso), .miso_oe_o(miso_oe),
        .parity_mode_enable_o(par_en), .parity_polarity_select_o(par_sel),
        .parity_ok_o(par_ok), .sensor_valid_o(s_valid)
    );

    spi_master_model m (
        .core_clk_i(core_clk), .miso_i(miso_w), .sck_o(sck),
        .mosi_o(mosi), .select_n_o(sel_n)
    );

    // --------------------------------------------------------
    // Helpers
    // --------------------------------------------------------
    task automatic conclude();
        if (n_fail == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    function automatic logic [15:0] mk(input logic [14:0] v);
        mk = {v, ~(^v)};
    endfunction : mk

    function automatic logic [15:0] adr(input logic [6:0] a, input logic rw);
        adr = mk({6'h00, a, rw, 1'b0});
    endfunction : adr

    task automatic xc(input logic [15:0] tx, input logic [15:0] exp);
        logic [15:0] got;
        m.xfer(tx, nbits, got);
        chk(got, exp);
        if (nbits == 17) begin
            chk({15'h0000, m.rx_ext}, {15'h0000, (m.par_odd ? ~(^got) : (^got))});
        end
    endtask : xc

    task automatic setf(input logic [13:0] f, input logic exp);
        flags <= f;
        repeat (2) @(posedge core_clk);
        chk({15'h0000, s_valid}, {15'h0000, exp});
    endtask : setf

    initial begin
        repeat (100000) @(posedge core_clk);
        n_fail++;
        conclude();
    end

    // --------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        rstn = 1'b0;
        rate = 14'h1234;
        temp = 14'h2ABC;
        flags = 14'h3FFF;
        miso_last = 1'b0;
        nbits = 16;
        n_fail = 0;
        cmp_count = 0;
        repeat (16) @(posedge core_clk);
        chk({miso_oe, miso, par_en, par_sel, par_ok}, 16'h0001);
        rstn <= 1'b1;
        repeat (4) @(posedge core_clk);
        setf(14'h3FFF, 1'b1);
        setf(14'h3F7F, 1'b1);
        setf(14'h1FFF, 1'b0);
        setf(14'h3FFF, 1'b1);
        // Plain mixed frame
        m.frame_begin();
        xc(adr(ADDR_TEMP, 1'b0), mk(15'h0001));
        xc(adr(ADDR_IDENT, 1'b1), mk({temp, 1'b1}));
        xc(mk(15'h1000), mk(15'h0000));
        xc(adr(7'h09, 1'b0), mk(15'h0001));
        xc(adr(7'h01, 1'b0), mk(15'h0000));
        xc(16'h0001, mk(15'h0000));
        m.frame_end();
        chk({14'h0000, par_en, par_sel}, 16'h0001);
        // Abandoned word, then a fresh frame
        m.frame_begin();
        m.xfer(adr(ADDR_RATE, 1'b0), 8, rx);
        m.frame_end();
        chk({15'h0000, miso_oe}, 16'h0000);
        m.frame_begin();
        xc(adr(ADDR_RATE, 1'b0), mk(15'h0001));
        xc(16'h0001, mk({rate, 1'b1}));
        m.frame_end();
        // Enable parity mode, odd polarity
        m.frame_begin();
        xc(adr(ADDR_IDENT, 1'b1), mk(15'h0001));
        xc(mk(15'h1800), mk(15'h1000));
        m.frame_end();
        chk({14'h0000, par_en, par_sel}, 16'h0003);
        nbits = 17;
        m.par_odd = 1'b1;
        m.frame_begin();
        xc(adr(ADDR_STATUS, 1'b0), mk(15'h0001));
        xc(adr(ADDR_RATE, 1'b0), mk({flags, 1'b0}));
        // Bad extra bit on a read, then on write data
        m.corrupt = 1'b1;
        m.xfer(adr(ADDR_RATE, 1'b0), 17, rx);
        m.corrupt = 1'b0;
        chk({14'h0000, rx[15:2] === rate, par_ok}, 16'h0002);
        m.xfer(adr(ADDR_IDENT, 1'b1), 17, rx);
        chk({2'b00, rx[15:2]}, {2'b00, rate});
        m.corrupt = 1'b1;
        m.xfer(mk(15'h0000), 17, rx);
        m.corrupt = 1'b0;
        chk({15'h0000, par_en}, 16'h0001);
        xc(adr(ADDR_STATUS, 1'b0), mk(15'h0000));
        xc(16'h0001, mk({flags[13:8], 1'b0, flags[6:0], 1'b0}));
        chk({15'h0000, par_ok}, 16'h0001);
        // Bad extra bit on a write address cancels a good data word
        m.corrupt = 1'b1;
        m.xfer(adr(ADDR_IDENT, 1'b1), 17, rx);
        m.corrupt = 1'b0;
        xc(mk(15'h0000), mk(15'h1800));
        chk({14'h0000, par_en, par_ok}, 16'h0002);
        m.frame_end();
        // Switch to even polarity and read back through it
        m.frame_begin();
        xc(adr(ADDR_IDENT, 1'b1), mk(15'h0000));
        xc(mk(15'h0800), mk(15'h1800));
        m.frame_end();
        chk({14'h0000, par_en, par_sel}, 16'h0002);
        m.par_odd = 1'b0;
        m.frame_begin();
        xc(adr(ADDR_IDENT, 1'b0), mk(15'h0000));
        xc(16'h0001, mk(15'h0800));
        m.frame_end();
        conclude();
    end
endmodule : gyro_spi_slave_parity_tb

`default_nettype wire
